// ### rtl/sup_reset_config.v
/*
 supervisor configuration decode with power-up delay and shared reset pin.
 assumes cfg_word and low_voltage_programming are valid while por_n is low
 and that external_reset_pin is synchronous to aclk.
 a bus reset clears outputs and bus state but keeps the latched word.
*/
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sup_map.vh"

module sup_reset_config #(
   parameter [23:0] PWRUP_CYCLES = `SUP_PWRUP_CYCLES
) (
   // clock and resets
   input wire aclk,
   input wire aresetn,
   input wire por_n,
   // non-volatile configuration
   input wire [13:0] cfg_word,
   input wire low_voltage_programming,
   // shared pin
   input wire external_reset_pin,
   output reg shared_general_input,
   // reset outputs
   output reg device_reset_n,
   output reg debug_enable,
   // axi4-lite write address
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// configuration latch

// the word is only trusted while por_n is low; afterwards the storage may
// read back anything, so nothing outside this latch looks at cfg_word
reg [13:0] cfg_q;
reg lv_prog_q;

// sampled on every por cycle, frozen once por_n rises; aresetn alone leaves it
always @(posedge aclk) begin
   if (!por_n) begin
      cfg_q <= cfg_word;
      lv_prog_q <= low_voltage_programming;
   end
end

// decoded enables; they stay fixed between two power-on cycles
wire delay_n = cfg_q[`SUP_BIT_PWRUP_DLY_N];
wire pin_en = cfg_q[`SUP_BIT_EXT_RESET_EN];
// low-voltage programming forces the reset function whatever the enable bit;
// with it off the enable bit alone picks reset function or plain input
wire pin_is_reset = lv_prog_q | pin_en;

////////////////////////////////////////////////////////////////////////////////
// reset generation

// soft reset is written over the bus and cleared again by a bus reset
reg soft_reset_q;
// limitation: the pin is taken as synchronous; a raw pin needs two flops first
wire pin_reset = pin_is_reset & ~external_reset_pin;
wire hold_reset = ~por_n | pin_reset | soft_reset_q;
wire delay_run = ~hold_reset & ~delay_n;
wire delay_done;

// the timer rearms whenever a cause comes back, so every release gets a full delay
sup_delay_timer #(
   .CYCLES(PWRUP_CYCLES)
) u_delay (
   .aclk(aclk),
   .aresetn(aresetn),
   .start(delay_run),
   .done(delay_done)
);

// with the delay disabled the reset lifts one cycle after its cause clears
always @(posedge aclk) begin
   if (!aresetn) begin
      device_reset_n <= 1'b0;
      shared_general_input <= 1'b0;
      debug_enable <= 1'b0;
   end else begin
      device_reset_n <= ~hold_reset & (delay_n | delay_done);
      // pin as plain input only when it is not the reset function
      shared_general_input <= ~pin_is_reset & external_reset_pin;
      // debug bit is whatever the tool programmed; active when cleared
      debug_enable <= ~cfg_q[`SUP_BIT_DEBUG_N];
   end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write channel

// capture flags: set by the take, cleared when the response goes out
reg aw_got_q;
reg w_got_q;
reg [3:0] aw_addr_q;
reg [31:0] w_data_q;
// only byte lane 0 matters: the control register has a single bit
reg w_strb0_q;

// address and data may arrive in either order; answer once both are held
always @(posedge aclk) begin
   if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SUP_RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb0_q <= 1'b0;
      soft_reset_q <= 1'b0;
   end else begin
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb0_q <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end
      // both halves held: decode and answer; only the control word is writable
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         s_axi_bvalid <= 1'b1;
         if (aw_addr_q == `SUP_OFS_CTRL) begin
            if (w_strb0_q)
               soft_reset_q <= w_data_q[0];
            s_axi_bresp <= `SUP_RESP_OKAY;
         end else begin
            s_axi_bresp <= `SUP_RESP_SLVERR; // config and status are read-only
         end
      end
      // readies return only once the response is taken: one write at a time
      if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read channel

reg [31:0] rd_mux;
reg rd_ok;
// decode follows araddr combinationally and is captured only at the take;
// the captured data then stand with rvalid until rready

// read decode
always @* begin
   rd_mux = 32'h00000000;
   rd_ok = 1'b1;
   if (s_axi_araddr == `SUP_OFS_CONFIG) begin
      rd_mux = {18'h00000, cfg_q};
   end else if (s_axi_araddr == `SUP_OFS_STATUS) begin
      // live view: bits may change between two reads
      rd_mux[`SUP_ST_IN_RESET] = ~device_reset_n;
      rd_mux[`SUP_ST_DELAY_ON] = ~delay_n;
      rd_mux[`SUP_ST_PIN_IS_RESET] = pin_is_reset;
      rd_mux[`SUP_ST_PIN_LEVEL] = external_reset_pin;
      rd_mux[`SUP_ST_LV_PROG] = lv_prog_q;
   end else if (s_axi_araddr == `SUP_OFS_CTRL) begin
      rd_mux = {31'h00000000, soft_reset_q};
   end else begin
      rd_ok = 1'b0;
   end
end

always @(posedge aclk) begin
   if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SUP_RESP_OKAY;
   end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `SUP_RESP_OKAY : `SUP_RESP_SLVERR;
   end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
   end
end

endmodule
`default_nettype wire

// ### rtl/sup_map.vh
/*
 supervisor configuration map: bit positions, reset values, register offsets
 and timing counts as macros. included by the supervisor design files.
*/
`ifndef SUP_MAP_VH
`define SUP_MAP_VH

// configuration word layout
`define SUP_CFG_W 14
`define SUP_BIT_EXT_RESET_EN 0
`define SUP_BIT_PWRUP_DLY_N 1
`define SUP_BIT_DEBUG_N 13
`define SUP_CFG_ERASED 14'h3FFF

// axi4-lite register byte offsets
`define SUP_OFS_CONFIG 4'h0
`define SUP_OFS_STATUS 4'h4
`define SUP_OFS_CTRL 4'h8

// status register bit positions
`define SUP_ST_IN_RESET 0
`define SUP_ST_DELAY_ON 1
`define SUP_ST_PIN_IS_RESET 2
`define SUP_ST_PIN_LEVEL 3
`define SUP_ST_LV_PROG 4

// power-up delay: 64 us at 200 mhz, kept as a 24-bit count to fit the timer
`define SUP_PWRUP_DELAY_US 64
`define SUP_CLK_MHZ 200
`define SUP_PWRUP_CYCLES 24'h003200

// axi responses
`define SUP_RESP_OKAY 2'h0
`define SUP_RESP_SLVERR 2'h2

`endif

// ### rtl/sup_delay_timer.v
/*
 power-up delay counter: counts a fixed number of cycles after start and
 then raises done. assumes start is a level held while the delay should run.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sup_map.vh"

module sup_delay_timer #(
   parameter [23:0] CYCLES = `SUP_PWRUP_CYCLES
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // control
   input wire start,
   output reg done
);

reg [23:0] count_q;

// count while start is high; dropping start rearms the timer
always @(posedge aclk) begin
   if (!aresetn || !start) begin
      count_q <= 24'h000000;
      done <= 1'b0;
   end else if (count_q < CYCLES) begin
      count_q <= count_q + 24'h000001;
   end else begin
      done <= 1'b1;
   end
end

endmodule
`default_nettype wire

// ### verif/sup_tool_model.sv
/* far-side model: programming tool and power-on source.
   assumes the bench asks for each power-on cycle. */
`timescale 1ns/1ps
`default_nettype none
module sup_tool_model (
   input wire logic aclk,
   input wire logic por_req,
   input wire logic lv_prog_in,
   input wire logic [13:0] word,
   output logic por_n = 1'b0,
   output logic [13:0] cfg_word,
   output logic low_voltage_programming
);
   // power-on pulse follows the bench request one edge later
   always @(posedge aclk) por_n <= !por_req;
   // storage valid only during power-on; inverse after it exposes late sampling
   // the tool alone picks the debug bit, 1 for normal runs
   assign cfg_word = por_n ? ~word : word;
   assign low_voltage_programming = por_n ? !lv_prog_in : lv_prog_in;
endmodule
`default_nettype wire

// ### verif/sup_reset_config_asserts.sv
/* checker for the supervisor decode.
   bound to sup_reset_config; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module sup_chk #(parameter [23:0] PWRUP_CYCLES = 24'h000008) (
   input wire logic aclk, input wire logic aresetn, input wire logic por_n,
   input wire logic [13:0] cfg_word, input wire logic low_voltage_programming,
   input wire logic external_reset_pin, input wire logic shared_general_input,
   input wire logic device_reset_n, input wire logic debug_enable,
   input wire logic s_axi_bvalid, input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp
);
   logic [13:0] cfg_q;
   logic lv_prog_q;
   logic [23:0] low_q = 24'h000000;
   // own copy of the latch, loaded like the design's while power-on is low
   always @(posedge aclk) begin
      if (!por_n) begin
         cfg_q <= cfg_word;
         lv_prog_q <= low_voltage_programming;
      end
      low_q <= device_reset_n ? 24'h000000 : low_q + 24'h000001;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_lowv_pin_reset: assert property (por_n && lv_prog_q && !external_reset_pin |=>
      !device_reset_n) else $error("pin low ignored under low-voltage programming");
   a_en_pin_reset: assert property (por_n && !lv_prog_q && cfg_q[0] && !external_reset_pin
      |=> !device_reset_n) else $error("pin low ignored while enabled");
   a_gpio_follow: assert property (por_n && !lv_prog_q && !cfg_q[0] |=>
      shared_general_input == $past(external_reset_pin)) else $error("input not followed");
   a_gpio_no_reset: assert property (por_n && !lv_prog_q && !cfg_q[0] && device_reset_n
      && !external_reset_pin |=> device_reset_n) else $error("general input reset device");
   a_delay_held: assert property ($rose(device_reset_n) && !cfg_q[1] |->
      low_q >= PWRUP_CYCLES) else $error("power-up delay too short");
   a_debug_held: assert property (por_n |=> !por_n || debug_enable == !cfg_q[13])
      else $error("debug enable not held");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write response dropped");
   c_lowv_pin: cover property (lv_prog_q && !external_reset_pin);
   c_gpio: cover property (!lv_prog_q && !cfg_q[0] && !external_reset_pin);
   c_delay: cover property ($rose(device_reset_n) && !cfg_q[1]);
endmodule
bind sup_reset_config sup_chk #(.PWRUP_CYCLES(PWRUP_CYCLES)) sup_chk_i (.aclk, .aresetn,
   .por_n, .cfg_word, .low_voltage_programming, .external_reset_pin, .shared_general_input,
   .device_reset_n, .debug_enable, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
`default_nettype wire

// ### verif/tb_sup_reset_config.sv
/* bench for the supervisor decode: bus tasks and pin scenarios.
   assumes the tool model supplies power-on and the word. */
`timescale 1ns/1ps
`default_nettype none
module tb_sup_reset_config;
   logic aclk = 0, aresetn = 0, external_reset_pin = 1, por_req = 1, lv_prog_in = 0;
   logic [13:0] word = 14'h3FFF;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, por_n, low_voltage_programming, shared_general_input;
   logic device_reset_n, debug_enable;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [13:0] cfg_word;
   int n_mismatch = 0, checked = 0;
   always #2.5 aclk = ~aclk;
   sup_tool_model sup_tool_model_i (.aclk, .por_req, .lv_prog_in, .word, .por_n, .cfg_word,
      .low_voltage_programming);
   sup_reset_config #(.PWRUP_CYCLES(24'd8)) sup_reset_config_i (.*);
   task summarize;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // a used-up wait counts as a mismatch and ends the run
   task to_chk(input int n);
      if (n == 40) begin
         n_mismatch++;
         summarize;
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      to_chk(n); cmp(s_axi_bresp, r); s_axi_bready <= 0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      to_chk(n); cmp(s_axi_rdata, d); cmp(s_axi_rresp, r); s_axi_rready <= 0;
   endtask
   task wait_rst;
      int n;
      for (n = 0; n < 40 && device_reset_n !== 1; n++) @(posedge aclk);
      to_chk(n);
   endtask
   task por(input logic [13:0] w, input logic l);
      word <= w; lv_prog_in <= l; por_req <= 1; repeat (3) @(posedge aclk);
      por_req <= 0; repeat (2) @(posedge aclk);
   endtask
   task pin(input logic v, input int c);
      external_reset_pin <= v; repeat (c) @(posedge aclk);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      // delay off, pin as general input, debug on
      por(14'h1FFE, 0); wait_rst;
      cmp(debug_enable, 1);
      pin(0, 3); cmp(device_reset_n, 1); cmp(shared_general_input, 0);
      pin(1, 3); cmp(shared_general_input, 1);
      rd(4'h0, 32'h1FFE, 2'h0);
      wr(4'h0, 32'h5, 2'h2); rd(4'hC, 32'h0, 2'h2);
      wr(4'h8, 32'h1, 2'h0); pin(1, 2); cmp(device_reset_n, 0);
      rd(4'h8, 32'h1, 2'h0); wr(4'h8, 32'h0, 2'h0); pin(1, 2); cmp(device_reset_n, 1);
      // delay on, pin enabled as reset
      por(14'h3FFD, 0); wait_rst; pin(0, 2); cmp(device_reset_n, 0);
      pin(1, 5); cmp(device_reset_n, 0);
      wait_rst; cmp(debug_enable, 0);
      rd(4'h4, 32'hE, 2'h0);
      // low-voltage programming forces the reset function
      por(14'h3FFE, 1); wait_rst; pin(0, 2); cmp(device_reset_n, 0);
      cmp(shared_general_input, 0); pin(1, 1); wait_rst;
      cmp(shared_general_input, 0);
      rd(4'h4, 32'h1C, 2'h0);
      // a bus reset in mid-run must leave the latched word alone
      aresetn <= 0; repeat (2) @(posedge aclk); aresetn <= 1;
      wait_rst; rd(4'h0, 32'h3FFE, 2'h0);
      summarize;
   end
endmodule
`default_nettype wire
